//--- sirq_pkg.sv
// shared constants and types for the serial interrupt slave agent
package sirq_pkg;

  // number of interrupt lines served, carried on slots 2 .. NUM_IRQ+1
  localparam int          NUM_IRQ         = 15;
  localparam int          SLOT_W          = 5;
  localparam int          RUN_W           = 2;

  // slot 1 is unused, slot 2 carries line 1
  localparam logic [4:0]  SLOT_FIRST_IRQ  = 5'h02;
  localparam logic [4:0]  SLOT_LAST       = 5'h10;
  // slot 3 carries line 2 or the management interrupt
  localparam logic [4:0]  SLOT_MGMT       = 5'h03;
  localparam int          MGMT_IRQ_IDX    = 1;
  // slot 14 carries line 13
  localparam logic [4:0]  SLOT_IRQ13      = 5'h0E;

  // stop pulse widths in clocks
  localparam logic [1:0]  STOP_QUIET_LOW  = 2'h2;
  localparam logic [1:0]  STOP_CONT_LOW   = 2'h3;
  localparam logic [1:0]  RUN_MAX         = 2'h3;

  // reset values
  localparam logic        IRQ_RST_LVL     = 1'b1;
  localparam logic        QUIET_RST       = 1'b0;

  typedef enum logic [1:0] {
    SIRQ_IDLE  = 2'b00,
    SIRQ_START = 2'b01,
    SIRQ_FRAME = 2'b10,
    SIRQ_STOP  = 2'b11
  } sirq_state_e;

  typedef enum logic [1:0] {
    SIRQ_PH_SAMPLE = 2'b00,
    SIRQ_PH_RECOV  = 2'b01,
    SIRQ_PH_TURN   = 2'b10
  } sirq_phase_e;

endpackage : sirq_pkg

//--- sirq_sync.sv
// two flip-flop synchroniser for a group of asynchronous level inputs
module sirq_sync #(
  parameter int   WIDTH   = 15,
  parameter logic RST_LVL = 1'b1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("sirq_sync: WIDTH must be at least 1");
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // first stage feeds only the second stage
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_reg <= RST_LVL;
          sync_reg <= RST_LVL;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate

endmodule : sirq_sync

//--- sirq_pend.sv
// per-line level capture and pending-change flags
module sirq_pend #(
  parameter int   WIDTH   = 15,
  parameter logic RST_LVL = 1'b1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] lvl_in,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] pend
);

  initial begin
    if (WIDTH < 1) begin
      $error("sirq_pend: WIDTH must be at least 1");
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      logic lvl_reg;
      logic pend_reg;
      logic change;
      logic pend_next;
      assign change    = lvl_in[i] ^ lvl_reg;
      // a change in the clearing cycle keeps the flag set
      assign pend_next = change | (pend_reg & ~clr[i]);
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lvl_reg  <= RST_LVL;
          pend_reg <= 1'b0;
        end else begin
          lvl_reg  <= lvl_in[i];
          pend_reg <= pend_next;
        end
      end
      assign lvl[i]  = lvl_reg;
      assign pend[i] = pend_reg;
    end
  endgenerate

endmodule : sirq_pend

//--- sirq_agent.sv
// serial interrupt slave agent: frame tracking, mode learning, slot driving
module sirq_agent
  import sirq_pkg::*;
#(
  parameter int NUM_LINES = sirq_pkg::NUM_IRQ
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic [NUM_LINES-1:0] irq_in,
  input  wire logic                 mgmt_irq_n,
  input  wire logic                 mgmt_slot_en,
  input  wire logic                 mgmt_pin_en,
  input  wire logic                 sirq_in,
  output logic                      sirq_out,
  output logic                      sirq_oe_n,
  output logic                      mgmt_irq_pin_n,
  output logic                      quiet_mode,
  output logic                      cycle_active
);

  import sirq_pkg::*;

  initial begin
    if (NUM_LINES < 2 || NUM_LINES > sirq_pkg::NUM_IRQ) begin
      $error("sirq_agent: NUM_LINES must be 2 .. 15");
    end
    if (SLOT_LAST != SLOT_W'(sirq_pkg::NUM_IRQ + 1)) begin
      $error("sirq_agent: last slot must follow the last served line");
    end
    if (SLOT_IRQ13 != SLOT_FIRST_IRQ + 5'h0C) begin
      $error("sirq_agent: line 13 must sit on slot 14");
    end
    // the mode decode only tells two widths apart
    if (STOP_CONT_LOW <= STOP_QUIET_LOW) begin
      $error("sirq_agent: stop widths must rise from quiet to continuous");
    end
  end

  localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(NUM_LINES + 1);

  // ---------------------------------------------------------------
  // interrupt lines: pins are synchronised, then merged with management
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] irq_sync;
  logic [NUM_LINES-1:0] irq_data;
  logic [NUM_LINES-1:0] irq_lvl;
  logic [NUM_LINES-1:0] irq_pend;
  logic [NUM_LINES-1:0] irq_clr;

  sirq_sync #(
    .WIDTH   (NUM_LINES),
    .RST_LVL (IRQ_RST_LVL)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (irq_in),
    .sync_out (irq_sync)
  );

  // slot 3 is shared: software keeps the two sources apart
  logic mgmt_on_slot;
  assign mgmt_on_slot = mgmt_irq_n | ~mgmt_slot_en;

  genvar k;
  generate
    for (k = 0; k < NUM_LINES; k++) begin : g_merge
      if (k == MGMT_IRQ_IDX) begin : g_mgmt
        assign irq_data[k] = irq_sync[k] & mgmt_on_slot;
      end else begin : g_plain
        assign irq_data[k] = irq_sync[k];
      end
    end
  endgenerate

  sirq_pend #(
    .WIDTH   (NUM_LINES),
    .RST_LVL (IRQ_RST_LVL)
  ) u_pend (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .lvl_in  (irq_data),
    .clr     (irq_clr),
    .lvl     (irq_lvl),
    .pend    (irq_pend)
  );

  // ---------------------------------------------------------------
  // line watching; the line is synchronous to ref_clk, so it is read raw
  // ---------------------------------------------------------------
  sirq_state_e       state_reg;
  sirq_state_e       state_next;
  sirq_phase_e       phase_reg;
  sirq_phase_e       phase_next;
  logic [SLOT_W-1:0] slot_reg;
  logic [SLOT_W-1:0] slot_next;
  logic [RUN_W-1:0]  run_reg;
  logic [RUN_W-1:0]  run_next;
  logic              quiet_reg;
  logic              quiet_next;
  logic              start_reg;
  logic              out_reg;
  logic              oe_n_reg;
  logic              mgmt_pin_reg;

  logic line_low;
  logic rise_seen;
  logic frame_begin;
  logic stop_end;

  assign line_low    = ~sirq_in;
  assign rise_seen   = sirq_in & (run_reg != '0);
  assign frame_begin = (state_reg == SIRQ_START) & rise_seen;
  assign stop_end    = (state_reg == SIRQ_STOP) & sirq_in;
  // run_reg saturates: only 1, 2 and 3-or-more low clocks matter
  assign run_next    = line_low ? ((run_reg == RUN_MAX) ? RUN_MAX : run_reg + 2'h1)
                                : '0;

  // data slots only ever hold the line low for one clock, so a second
  // consecutive low clock inside a frame can only be the stop pulse
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SIRQ_IDLE: begin
        if (line_low) begin
          state_next = SIRQ_START;
        end
      end
      SIRQ_START: begin
        if (rise_seen) begin
          state_next = SIRQ_FRAME;
        end
      end
      SIRQ_FRAME: begin
        if (line_low && run_reg != '0) begin
          state_next = SIRQ_STOP;
        end
      end
      SIRQ_STOP: begin
        // idle clocks after the stop are simply idle state
        if (sirq_in) begin
          state_next = SIRQ_IDLE;
        end
      end
    endcase
  end

  // a 2-clock stop selects quiet mode, anything longer continuous; a stretched
  // stop therefore never hands the agent the right to start frames itself
  assign quiet_next = stop_end ? (run_reg == STOP_QUIET_LOW) : quiet_reg;

  // ---------------------------------------------------------------
  // slot and phase counting from the rise that ends the start pulse:
  // rise clock is 0, clock 1 is a turn-around, clock 2 samples slot 1
  // ---------------------------------------------------------------
  logic in_frame_next;
  logic slot_more;

  assign in_frame_next = (state_next == SIRQ_FRAME);
  // counting halts past the last slot, so a long host frame cannot wrap
  assign slot_more     = (slot_reg <= SLOT_LAST);

  always_comb begin
    phase_next = phase_reg;
    slot_next  = slot_reg;
    if (frame_begin) begin
      phase_next = SIRQ_PH_TURN;
      slot_next  = '0;
    end else if (state_reg == SIRQ_FRAME && slot_more) begin
      unique case (phase_reg)
        SIRQ_PH_TURN: begin
          phase_next = SIRQ_PH_SAMPLE;
          slot_next  = slot_reg + 5'h01;
        end
        SIRQ_PH_SAMPLE: begin
          phase_next = SIRQ_PH_RECOV;
        end
        SIRQ_PH_RECOV: begin
          phase_next = SIRQ_PH_TURN;
        end
        default: begin
          phase_next = SIRQ_PH_TURN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // slot driving, decided one clock ahead so the pin comes from a flop
  // ---------------------------------------------------------------
  logic [3:0] slot_idx;
  logic       slot_owned;
  logic       slot_lvl;
  logic       sample_now;
  logic       recov_now;
  logic       drive_low_next;
  logic       drive_high_next;
  logic       drove_low;
  logic       start_req;
  logic       oe_n_next;

  assign slot_idx   = 4'(slot_next - SLOT_FIRST_IRQ);
  assign slot_owned = (slot_next >= SLOT_FIRST_IRQ) && (slot_next <= SLOT_END);
  assign slot_lvl   = slot_owned ? irq_lvl[slot_idx] : 1'b1;
  assign sample_now = in_frame_next && (phase_next == SIRQ_PH_SAMPLE);

  assign drive_low_next  = sample_now && slot_owned && !slot_lvl;
  assign drove_low       = !oe_n_reg && !out_reg && !start_reg;
  assign recov_now       = in_frame_next && (phase_next == SIRQ_PH_RECOV);
  assign drive_high_next = recov_now && drove_low;

  // the level sent in a slot is the delivered value, so its pending flag
  // drops in that slot's sample clock, driven low or not; a later change sets it again
  generate
    for (k = 0; k < NUM_LINES; k++) begin : g_clr
      assign irq_clr[k] = sample_now && (slot_next == SLOT_W'(k + 2));
    end
  endgenerate

  // only from idle state, so never inside an active cycle; idle state is
  // entered the clock after the stop rise, so the earliest pulse lands on the
  // second clock after that rise; quiet_reg is low in continuous mode
  logic idle_line;
  logic any_pend;
  assign idle_line = (state_reg == SIRQ_IDLE) && sirq_in;
  assign any_pend  = |irq_pend;
  assign start_req = idle_line && quiet_reg && any_pend && !start_reg;

  // turn-around leaves the pin released; idle does too, save for the quiet-mode start pulse
  assign oe_n_next = ~(drive_low_next | drive_high_next | start_req);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SIRQ_IDLE;
      phase_reg <= SIRQ_PH_TURN;
      slot_reg  <= '0;
      run_reg   <= '0;
      quiet_reg <= QUIET_RST;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      slot_reg  <= slot_next;
      run_reg   <= run_next;
      quiet_reg <= quiet_next;
    end
  end

  // pin flops: released while the bus reset is held
  // sirq_out carries meaning only while sirq_oe_n is low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= 1'b0;
      out_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
    end else begin
      start_reg <= start_req;
      out_reg   <= drive_high_next;
      oe_n_reg  <= oe_n_next;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // registered so the pin cannot glitch while the enable moves
      mgmt_pin_reg <= 1'b1;
    end else begin
      mgmt_pin_reg <= mgmt_irq_n | ~mgmt_pin_en;
    end
  end

  assign sirq_out       = out_reg;
  assign sirq_oe_n      = oe_n_reg;
  assign mgmt_irq_pin_n = mgmt_pin_reg;
  assign quiet_mode     = quiet_reg;
  assign cycle_active   = (state_reg != SIRQ_IDLE);

endmodule : sirq_agent

//--- sirq_agent_chk.sv
// concurrent checks on the serial interrupt agent ports
module sirq_agent_chk #(
  parameter int NUM_LINES = 15
) (
  input wire logic                 ref_clk,
  input wire logic                 sys_rst,
  input wire logic [NUM_LINES-1:0] irq_in,
  input wire logic                 mgmt_irq_n,
  input wire logic                 mgmt_slot_en,
  input wire logic                 mgmt_pin_en,
  input wire logic                 sirq_in,
  input wire logic                 sirq_out,
  input wire logic                 sirq_oe_n,
  input wire logic                 mgmt_irq_pin_n,
  input wire logic                 quiet_mode,
  input wire logic                 cycle_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic       got_reg;
  logic       in_d_reg;
  logic [6:0] pos_reg;
  wire        drv_lo = !sirq_oe_n && !sirq_out;
  wire        drv_hi = !sirq_oe_n && sirq_out;
  // clocks past the start pulse rise; a device start pulse is seen with got_reg low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      got_reg  <= 1'b0;
      in_d_reg <= 1'b1;
      pos_reg  <= 7'h00;
    end else begin
      in_d_reg <= sirq_in;
      if (!cycle_active) begin
        got_reg <= 1'b0;
        pos_reg <= 7'h00;
      end else if (got_reg) begin
        pos_reg <= pos_reg + 7'h01;
      end else if (sirq_in && !in_d_reg) begin
        got_reg <= 1'b1;
        pos_reg <= 7'h01;
      end
    end
  end
  property p_turn; drv_hi |=> sirq_oe_n; endproperty
  a_turn: assert property (p_turn) else $error("no release after recovery");
  property p_recov; got_reg && drv_lo |=> drv_hi; endproperty
  a_recov: assert property (p_recov) else $error("no recovery drive");
  property p_slot; got_reg && drv_lo |-> pos_reg % 7'h03 == 7'h02 && pos_reg >= 7'h05
    && pos_reg <= 7'h2F; endproperty
  a_slot: assert property (p_slot) else $error("slot drive off grid");
  property p_passive; !quiet_mode && !cycle_active |-> sirq_oe_n; endproperty
  a_passive: assert property (p_passive) else $error("drive in continuous idle");
  property p_start; drv_lo && !got_reg |-> quiet_mode && !cycle_active
    && !$past(cycle_active) && $past(sirq_in); endproperty
  a_start: assert property (p_start) else $error("start pulse not allowed");
  property p_rst; $fell(sys_rst) |-> sirq_oe_n && !quiet_mode && !cycle_active; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_pin; mgmt_pin_en && !mgmt_irq_n |=> !mgmt_irq_pin_n; endproperty
  a_pin: assert property (p_pin) else $error("management pin not asserted");
  property p_mode; !$stable(quiet_mode) |-> $fell(cycle_active); endproperty
  a_mode: assert property (p_mode) else $error("mode change outside stop");
  property p_q2; (got_reg && sirq_in) ##1 (!sirq_in)[*2] ##1 sirq_in |=> quiet_mode; endproperty
  a_q2: assert property (p_q2) else $error("quiet not learnt");
  property p_c3; (got_reg && sirq_in) ##1 (!sirq_in)[*3] ##1 sirq_in |=> !quiet_mode; endproperty
  a_c3: assert property (p_c3) else $error("continuous not learnt");
endmodule : sirq_agent_chk

//--- sirq_host_model.sv
// behavioural host controller making start and stop frames
module sirq_host_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       sirq_in,
  input  wire logic       go,
  input  wire logic [3:0] start_w,
  input  wire logic [1:0] stop_w,
  output logic            host_out,
  output logic            host_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_reg;
  logic [6:0] cnt_reg;
  wire  [6:0] rise_c = {3'h0, start_w};
  wire  [6:0] stop_c = rise_c + 7'h32;
  wire  [6:0] end_c  = stop_c + {5'h00, stop_w};
  wire        low_c  = cnt_reg < rise_c || (cnt_reg >= stop_c && cnt_reg < end_c);
  assign host_oe_n = !(busy_reg && (cnt_reg <= rise_c || cnt_reg >= stop_c));
  assign host_out  = !low_c;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 7'h00;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg + 7'h01;
      busy_reg <= cnt_reg != end_c;
    end else if (go || !sirq_in) begin
      busy_reg <= 1'b1;
      // an agent's one-clock pulse counts towards the total start width
      cnt_reg  <= go ? 7'h00 : 7'h01;
    end
  end
endmodule : sirq_host_model

//--- serial_irq_slave_agent_bench.sv
// self-checking bench for the serial interrupt slave agent
module serial_irq_slave_agent_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sirq_pkg::*;
  logic               ref_clk, sys_rst, go, mgmt_irq_n, mgmt_slot_en, mgmt_pin_en;
  logic [NUM_IRQ-1:0] irq_in;
  logic [3:0]         start_w;
  logic [1:0]         stop_w;
  logic               sirq_out, sirq_oe_n, mgmt_irq_pin_n, quiet_mode, cycle_active;
  logic               host_out, host_oe_n;
  int                 fails, n_tests;
  // pulled-up wire: any enabled driver pulling low wins
  wire sirq_in = !((!sirq_oe_n && !sirq_out) || (!host_oe_n && !host_out));
  sirq_agent dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .irq_in(irq_in),
    .mgmt_irq_n(mgmt_irq_n), .mgmt_slot_en(mgmt_slot_en), .mgmt_pin_en(mgmt_pin_en),
    .sirq_in(sirq_in), .sirq_out(sirq_out), .sirq_oe_n(sirq_oe_n),
    .mgmt_irq_pin_n(mgmt_irq_pin_n), .quiet_mode(quiet_mode), .cycle_active(cycle_active));
  sirq_host_model host (.ref_clk(ref_clk), .sys_rst(sys_rst), .sirq_in(sirq_in), .go(go),
    .start_w(start_w), .stop_w(stop_w), .host_out(host_out), .host_oe_n(host_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic wait_act(input logic want);
    int i;
    for (i = 0; i < 90 && cycle_active !== want; i++)
      step();
    if (cycle_active !== want) begin
      check(17'(cycle_active), 17'(want));
      final_report();
    end
  endtask : wait_act
  // slot 2 carries line 1; slot 3 also carries the gated management level
  function automatic logic [16:0] slots(input logic [14:0] lv, input logic mn, input logic en);
    logic [16:0] m;
    m = {~lv, 2'b00};
    m[3] = !(lv[1] && (mn || !en));
    return m;
  endfunction : slots
  task automatic run_frame(input logic [16:0] exp, input logic hold);
    logic [16:0] seen;
    logic        lo;
    int          k;
    seen = 17'h00000;
    lo = 1'b0;
    wait_act(1'b1);
    go = hold;
    for (k = 0; k < 20 && !(lo && sirq_in); k++) begin
      lo = lo || !sirq_in;
      step();
    end
    // a start pulse that never ends is a hang, not a pass
    if (!(lo && sirq_in)) begin
      check(17'(lo && sirq_in), 17'h00001);
      final_report();
    end
    for (k = 1; k < 50; k++) begin
      step();
      if (k % 3 == 2)
        seen[(k + 1) / 3] = !sirq_oe_n && !sirq_out;
    end
    check(seen, exp);
    wait_act(1'b0);
  endtask : run_frame
  task automatic t_reset;
    check(17'({sirq_oe_n, quiet_mode, cycle_active, mgmt_irq_pin_n}), 17'h00009);
  endtask : t_reset
  task automatic t_cont;
    logic act;
    irq_in = 15'h6FFE;
    repeat (4) step();
    go = 1'b1;
    run_frame(slots(15'h6FFE, 1'b1, 1'b0), 1'b0);
    check(17'(quiet_mode), 17'h00000);
    irq_in = 15'h7FFF;
    act = 1'b0;
    repeat (60) begin
      step();
      act = act | cycle_active;
    end
    check(17'(act), 17'h00000);
  endtask : t_cont
  task automatic t_mgmt;
    mgmt_irq_n = 1'b0;
    mgmt_slot_en = 1'b1;
    mgmt_pin_en = 1'b1;
    repeat (4) step();
    check(17'(mgmt_irq_pin_n), 17'h00000);
    go = 1'b1;
    run_frame(slots(15'h7FFF, 1'b0, 1'b1), 1'b0);
    mgmt_slot_en = 1'b0;
    mgmt_pin_en = 1'b0;
    repeat (2) step();
    check(17'(mgmt_irq_pin_n), 17'h00001);
  endtask : t_mgmt
  task automatic t_quiet;
    stop_w = 2'h2;
    start_w = 4'h8;
    irq_in = 15'h7FFD;
    repeat (4) step();
    go = 1'b1;
    run_frame(slots(15'h7FFD, 1'b0, 1'b0), 1'b0);
    check(17'(quiet_mode), 17'h00001);
    repeat (10) step();
    check(17'(cycle_active), 17'h00000);
    stop_w = 2'h3;
    irq_in = 15'h3FFD;
    // no host request: the agent must open this frame itself
    run_frame(slots(15'h3FFD, 1'b0, 1'b0), 1'b0);
    check(17'(quiet_mode), 17'h00000);
  endtask : t_quiet
  task automatic t_b2b;
    start_w = 4'h4;
    go = 1'b1;
    run_frame(slots(15'h3FFD, 1'b0, 1'b0), 1'b1);
    run_frame(slots(15'h3FFD, 1'b0, 1'b0), 1'b0);
  endtask : t_b2b
  // reset in quiet mode: the resync of the low lines after release looks
  // like a change, yet the agent must wait for the host again
  task automatic t_midrst;
    stop_w = 2'h2;
    go = 1'b1;
    run_frame(slots(15'h3FFD, 1'b0, 1'b0), 1'b0);
    check(17'(quiet_mode), 17'h00001);
    sys_rst = 1'b1;
    step();
    check(17'({sirq_oe_n, sirq_in, quiet_mode, cycle_active}), 17'h0000C);
    sys_rst = 1'b0;
    repeat (20) step();
    check(17'(cycle_active), 17'h00000);
  endtask : t_midrst
  initial begin
    sys_rst = 1'b1;
    go = 1'b0;
    irq_in = 15'h7FFF;
    mgmt_irq_n = 1'b1;
    mgmt_slot_en = 1'b0;
    mgmt_pin_en = 1'b0;
    start_w = 4'h4;
    stop_w = 2'h3;
    fails = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    t_reset();
    sys_rst = 1'b0;
    t_cont();
    t_mgmt();
    t_quiet();
    t_b2b();
    t_midrst();
    final_report();
  end
endmodule : serial_irq_slave_agent_bench
bind sirq_agent sirq_agent_chk #(.NUM_LINES(NUM_LINES)) chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .irq_in(irq_in), .mgmt_irq_n(mgmt_irq_n), .mgmt_slot_en(mgmt_slot_en),
  .mgmt_pin_en(mgmt_pin_en), .sirq_in(sirq_in), .sirq_out(sirq_out), .sirq_oe_n(sirq_oe_n),
  .mgmt_irq_pin_n(mgmt_irq_pin_n), .quiet_mode(quiet_mode), .cycle_active(cycle_active));
